// file: rtl/crspc_top.sv
// pin function control for the request / halt dual-use pins
// assumes all pin inputs and source clock phases are synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - pair 11 complement pin becomes active-low request for pair 9 when its bit is set.
// - pair 11 disabled by either of its enable bits puts both its pins in high impedance.
// - pair 11 true pin becomes active-low request for pair 10 when its bit is set.
// - strap caught after reset picks halt inputs (0) or pair 5 output (1).
// - low cpu halt stops every cpu output not marked free-running.
// - outside management mode, low pci halt stops every pci output not marked free-running.
// - management mode shifts three bits in, loaded as freq_sel_c, b, a.
// - in management mode, with the strap at 0 (halt inputs), the pci halt pin clocks the serial select bits.
module crspc_top (
  input wire logic ref_clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and straps
  input wire logic pair5_function_strap,
  input wire logic management_mode,
  input wire logic mgmt_serial_data,
  input wire logic [crspc_pkg::N_GATE-1:0] src_clk,
  input wire logic periph_pair_11_src,
  input wire logic periph_pair_5_src,
  input wire logic request_in_g_n_in,
  output logic request_in_g_n_out,
  output logic request_in_g_n_oe_n,
  input wire logic request_in_h_n_in,
  output logic request_in_h_n_out,
  output logic request_in_h_n_oe_n,
  input wire logic cpu_halt_n_in,
  output logic cpu_halt_n_out,
  output logic cpu_halt_n_oe_n,
  input wire logic pci_halt_n_in,
  output logic pci_halt_n_out,
  output logic pci_halt_n_oe_n,
  output logic [crspc_pkg::N_GATE-1:0] gated_clk,
  output logic freq_sel_c,
  output logic freq_sel_b,
  output logic freq_sel_a
);
  // ----------------------------------------
  // synchronisers and strap capture
  // ----------------------------------------
  logic [crspc_pkg::SYNC_W-1:0] meta_reg, sync_reg, sync_d_reg;
  logic [crspc_pkg::SYNC_W-1:0] raw_in;
  logic strap_reg, strap_next, strap_done_reg, strap_done_next;

  // first stage is read only by the second
  always_comb begin
    raw_in = '0;
    raw_in[crspc_pkg::SY_CPU] = cpu_halt_n_in;
    raw_in[crspc_pkg::SY_PCI] = pci_halt_n_in;
    raw_in[crspc_pkg::SY_G] = request_in_g_n_in;
    raw_in[crspc_pkg::SY_H] = request_in_h_n_in;
    raw_in[crspc_pkg::SY_SD] = mgmt_serial_data;
    strap_done_next = 1'b1;
    strap_next = strap_done_reg ? strap_reg : pair5_function_strap;
  end

  // strap is caught on the first edge after release, never under reset
  always_ff @(posedge ref_clk) begin
    meta_reg <= raw_in;
    sync_reg <= meta_reg;
    sync_d_reg <= sync_reg;
    if (reset) begin
      strap_done_reg <= 1'b0;
      strap_reg <= 1'b0;
    end else begin
      strap_done_reg <= strap_done_next;
      strap_reg <= strap_next;
    end
  end

  // ----------------------------------------
  // axi4-lite slave and registers
  // ----------------------------------------
  logic [7:0] out_en_reg, out_en_next, req_cfg_reg, req_cfg_next;
  logic [8:0] free_reg, free_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_next, merged, status_word;
  logic [3:0] wstrb_reg, wstrb_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic bvalid_next, rvalid_next, awready_next, wready_next, arready_next;
  logic [1:0] bresp_next, rresp_next;
  logic fs_c_reg, fs_b_reg, fs_a_reg;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // one write and one read at a time; address and data taken in either order
  always_comb begin
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    out_en_next = out_en_reg;
    req_cfg_next = req_cfg_reg;
    free_next = free_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    rvalid_next = s_axi_rvalid;
    rresp_next = s_axi_rresp;
    rdata_next = s_axi_rdata;
    merged = '0;
    status_word = {24'h000000, fs_c_reg, fs_b_reg, fs_a_reg, strap_reg,
                   sync_reg[crspc_pkg::SY_H], sync_reg[crspc_pkg::SY_G],
                   sync_reg[crspc_pkg::SY_PCI], sync_reg[crspc_pkg::SY_CPU]};
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_next = s_axi_awaddr;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      w_have_next = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) bvalid_next = 1'b0;
    if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = crspc_pkg::RESP_OKAY;
      case (awaddr_reg)
        crspc_pkg::ADDR_OUT_EN: begin
          merged = merge_bytes({24'h000000, out_en_reg}, wdata_reg, wstrb_reg);
          out_en_next = merged[7:0];
        end
        crspc_pkg::ADDR_REQ_CFG: begin
          merged = merge_bytes({24'h000000, req_cfg_reg}, wdata_reg, wstrb_reg);
          req_cfg_next = merged[7:0];
        end
        crspc_pkg::ADDR_FREE: begin
          merged = merge_bytes({23'h000000, free_reg}, wdata_reg, wstrb_reg);
          free_next = merged[8:0];
        end
        crspc_pkg::ADDR_STATUS: ; // read only, write ignored
        default: bresp_next = crspc_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = crspc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        crspc_pkg::ADDR_OUT_EN: rdata_next = {24'h000000, out_en_reg};
        crspc_pkg::ADDR_REQ_CFG: rdata_next = {24'h000000, req_cfg_reg};
        crspc_pkg::ADDR_FREE: rdata_next = {23'h000000, free_reg};
        crspc_pkg::ADDR_STATUS: rdata_next = status_word;
        default: begin
          rdata_next = '0;
          rresp_next = crspc_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
    arready_next = !rvalid_next;
  end

  // bus and register state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_en_reg <= crspc_pkg::OUT_EN_RST;
      req_cfg_reg <= crspc_pkg::REQ_CFG_RST;
      free_reg <= crspc_pkg::FREE_RST;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= crspc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= crspc_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      out_en_reg <= out_en_next;
      req_cfg_reg <= req_cfg_next;
      free_reg <= free_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_arready <= arready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
    end
  end

  // ----------------------------------------
  // serial frequency-select loader
  // ----------------------------------------
  logic [1:0] fs_shift_reg, fs_shift_next, fs_cnt_reg, fs_cnt_next;
  logic fs_c_next, fs_b_next, fs_a_next, ser_rise, ser_load;

  // halt pin is the shift clock only while it is an input
  always_comb begin
    ser_rise = management_mode && strap_reg == crspc_pkg::STRAP_HALT &&
               sync_reg[crspc_pkg::SY_PCI] && !sync_d_reg[crspc_pkg::SY_PCI];
    ser_load = ser_rise && fs_cnt_reg == crspc_pkg::FS_LAST;
    fs_shift_next = fs_shift_reg;
    fs_cnt_next = management_mode ? fs_cnt_reg : 2'h0;
    {fs_c_next, fs_b_next, fs_a_next} = {fs_c_reg, fs_b_reg, fs_a_reg};
    if (ser_rise) begin
      fs_shift_next = {fs_shift_reg[0], sync_reg[crspc_pkg::SY_SD]};
      fs_cnt_next = ser_load ? 2'h0 : fs_cnt_reg + 2'h1;
    end
    // first bit in is c, last is a
    if (ser_load) begin
      {fs_c_next, fs_b_next, fs_a_next} = {fs_shift_reg, sync_reg[crspc_pkg::SY_SD]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fs_shift_reg <= '0;
      fs_cnt_reg <= '0;
      fs_c_reg <= 1'b0;
      fs_b_reg <= 1'b0;
      fs_a_reg <= 1'b0;
    end else begin
      fs_shift_reg <= fs_shift_next;
      fs_cnt_reg <= fs_cnt_next;
      fs_c_reg <= fs_c_next;
      fs_b_reg <= fs_b_next;
      fs_a_reg <= fs_a_next;
    end
  end
  assign freq_sel_c = fs_c_reg;
  assign freq_sel_b = fs_b_reg;
  assign freq_sel_a = fs_a_reg;

  // ----------------------------------------
  // pin direction and drive
  // ----------------------------------------
  logic pair11_on, halt_fn;
  always_comb begin
    pair11_on = out_en_reg[crspc_pkg::BIT_P11_COMP_EN] &&
                out_en_reg[crspc_pkg::BIT_P11_TRUE_EN];
    halt_fn = strap_done_reg && strap_reg == crspc_pkg::STRAP_HALT;
  end

  // request function wins over drive, so a skipped disable cannot fight the host
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      request_in_g_n_out <= 1'b0;
      request_in_h_n_out <= 1'b0;
      request_in_g_n_oe_n <= 1'b1;
      request_in_h_n_oe_n <= 1'b1;
      cpu_halt_n_out <= 1'b0;
      pci_halt_n_out <= 1'b0;
      cpu_halt_n_oe_n <= 1'b1;
      pci_halt_n_oe_n <= 1'b1;
    end else begin
      request_in_g_n_out <= !periph_pair_11_src;
      request_in_h_n_out <= periph_pair_11_src;
      request_in_g_n_oe_n <= !pair11_on || req_cfg_reg[crspc_pkg::BIT_REQ_G_EN];
      request_in_h_n_oe_n <= !pair11_on || req_cfg_reg[crspc_pkg::BIT_REQ_H_EN];
      cpu_halt_n_out <= !periph_pair_5_src;
      pci_halt_n_out <= periph_pair_5_src;
      cpu_halt_n_oe_n <= !(strap_done_reg && strap_reg != crspc_pkg::STRAP_HALT);
      pci_halt_n_oe_n <= !(strap_done_reg && strap_reg != crspc_pkg::STRAP_HALT);
    end
  end

  // ----------------------------------------
  // glitch-free gating of the clock outputs
  // ----------------------------------------
  logic [crspc_pkg::N_GATE-1:0] stop_req, gate_en_reg, gate_en_next, gated_next;
  logic cpu_stop, pci_stop;

  // pci halt is a shift clock in management mode, not a halt
  always_comb begin
    cpu_stop = halt_fn && !sync_reg[crspc_pkg::SY_CPU];
    pci_stop = halt_fn && !management_mode && !sync_reg[crspc_pkg::SY_PCI];
    stop_req = '0;
    stop_req[crspc_pkg::N_CPU-1:0] = {crspc_pkg::N_CPU{cpu_stop}} &
                                     ~free_reg[crspc_pkg::N_CPU-1:0];
    stop_req[crspc_pkg::CH_PCI0 +: crspc_pkg::N_PCI] = {crspc_pkg::N_PCI{pci_stop}} &
                                     ~free_reg[crspc_pkg::CH_PCI0 +: crspc_pkg::N_PCI];
    stop_req[crspc_pkg::CH_P9] = req_cfg_reg[crspc_pkg::BIT_REQ_G_EN] &&
                                 sync_reg[crspc_pkg::SY_G];
    stop_req[crspc_pkg::CH_P10] = req_cfg_reg[crspc_pkg::BIT_REQ_H_EN] &&
                                  sync_reg[crspc_pkg::SY_H];
  end

  // enable may only move while the source is low
  for (genvar g = 0; g < crspc_pkg::N_GATE; g++) begin : g_gate
    always_comb begin
      gate_en_next[g] = src_clk[g] ? gate_en_reg[g] : !stop_req[g];
      gated_next[g] = src_clk[g] && gate_en_next[g];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gate_en_reg <= '1;
      gated_clk <= '0;
    end else begin
      gate_en_reg <= gate_en_next;
      gated_clk <= gated_next;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_req_g_input;
    req_cfg_reg[crspc_pkg::BIT_REQ_G_EN] |=> request_in_g_n_oe_n;
  endproperty
  a_req_g_input: assert property (p_req_g_input) else $error("g pin driven as request");

  property p_pair11_hiz;
    !(out_en_reg[crspc_pkg::BIT_P11_COMP_EN] && out_en_reg[crspc_pkg::BIT_P11_TRUE_EN]) |=>
      request_in_g_n_oe_n && request_in_h_n_oe_n;
  endproperty
  a_pair11_hiz: assert property (p_pair11_hiz) else $error("disabled pair 11 driven");

  property p_req_h_input;
    req_cfg_reg[crspc_pkg::BIT_REQ_H_EN] |=> request_in_h_n_oe_n;
  endproperty
  a_req_h_input: assert property (p_req_h_input) else $error("h pin driven as request");

  property p_strap_dir;
    strap_done_reg ##1 1'b1 |-> cpu_halt_n_oe_n == ($past(strap_reg) == crspc_pkg::STRAP_HALT);
  endproperty
  a_strap_dir: assert property (p_strap_dir) else $error("halt pin direction wrong");

  property p_cpu_stop;
    cpu_stop && !free_reg[0] && !src_clk[0] ##1 !src_clk[0] |=> !gated_clk[0];
  endproperty
  a_cpu_stop: assert property (p_cpu_stop) else $error("cpu clock not stopped");

  property p_pci_stop;
    pci_stop && !free_reg[crspc_pkg::CH_PCI0] |=> !gate_en_reg[crspc_pkg::CH_PCI0] ||
      $past(src_clk[crspc_pkg::CH_PCI0]);
  endproperty
  a_pci_stop: assert property (p_pci_stop) else $error("pci clock not stopped");

  property p_fs_load;
    ser_load |=> {fs_c_reg, fs_b_reg, fs_a_reg} ==
      {$past(fs_shift_reg), $past(sync_reg[crspc_pkg::SY_SD])};
  endproperty
  a_fs_load: assert property (p_fs_load) else $error("select bits misloaded");

  property p_fs_only_on_edge;
    {fs_c_reg, fs_b_reg, fs_a_reg} != $past({fs_c_reg, fs_b_reg, fs_a_reg}) |-> $past(ser_load);
  endproperty
  a_fs_only_on_edge: assert property (p_fs_only_on_edge) else $error("select moved alone");

  property p_gate_low_phase;
    ((gate_en_reg ^ $past(gate_en_reg)) & $past(src_clk)) == '0;
  endproperty
  a_gate_low_phase: assert property (p_gate_low_phase) else $error("gate moved in high phase");

  c_fs_load: cover property (ser_load);
  c_cpu_stopped: cover property (cpu_stop ##3 !gate_en_reg[0]);
  c_req_g_gates: cover property (stop_req[crspc_pkg::CH_P9] ##3 !gate_en_reg[crspc_pkg::CH_P9]);
  c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == crspc_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

// file: shared/crspc_pkg.sv
// constants for the clock-request / stop pin control block
// assumes a 125 MHz ref_clk and an AXI4-Lite master on the register side
`default_nettype none
package crspc_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_OUT_EN = 8'h0c; // output enable image
  localparam logic [7:0] ADDR_REQ_CFG = 8'h18; // request-pin function image
  localparam logic [7:0] ADDR_FREE = 8'h20; // free-running masks
  localparam logic [7:0] ADDR_STATUS = 8'h24; // read-only state
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int BIT_P11_COMP_EN = 7;
  localparam int BIT_P11_TRUE_EN = 6;
  localparam int BIT_REQ_G_EN = 5;
  localparam int BIT_REQ_H_EN = 4;
  localparam logic [7:0] OUT_EN_RST = 8'hc0;
  localparam logic [7:0] REQ_CFG_RST = 8'h00;
  localparam logic [8:0] FREE_RST = 9'h000;
  localparam logic STRAP_HALT = 1'b0; // strap 0: halt inputs, 1: pair 5
  // ----------------------------------------
  // sizes and channel indices of the gated outputs
  // ----------------------------------------
  localparam int N_CPU = 3;
  localparam int N_PCI = 6;
  localparam int N_GATE = 11; // cpu 0..2, pci 3..8, pair 9, pair 10
  localparam int CH_PCI0 = 3;
  localparam int CH_P9 = 9;
  localparam int CH_P10 = 10;
  localparam int FS_BITS = 3;
  localparam logic [1:0] FS_LAST = 2'h2; // index of the third serial bit
  // synchroniser lanes
  localparam int SY_CPU = 0;
  localparam int SY_PCI = 1;
  localparam int SY_G = 2;
  localparam int SY_H = 3;
  localparam int SY_SD = 4;
  localparam int SYNC_W = 5;
  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: testbench/crspc_host_model.sv
// far-side model: chipset halt/request pin drivers and serial select shifter
// assumes the bench resolves every shared pin from the device's output enables
`timescale 1ns/1ns
`default_nettype none
module crspc_host_model (
  input wire logic ref_clk,
  output logic cpu_halt_n,
  output logic pci_halt_n,
  output logic req_g_n,
  output logic req_h_n,
  output logic serial_data
);
  // ------------------------------------------------
  // pin levels
  // ------------------------------------------------
  // idle: halts and requests deasserted, serial clock parked high
  initial begin
    cpu_halt_n = 1'b1;
    pci_halt_n = 1'b1;
    req_g_n = 1'b1;
    req_h_n = 1'b1;
    serial_data = 1'b0;
  end

  // levels change just after an edge, never on it
  task automatic set_pins(input logic c, input logic p, input logic g, input logic h);
    @(posedge ref_clk);
    cpu_halt_n <= c;
    pci_halt_n <= p;
    req_g_n <= g;
    req_h_n <= h;
  endtask

  // first bit shifted is c; 4-cycle phases so the 2-flop sync cannot miss one
  task automatic shift_sel(input logic [2:0] v);
    for (int i = 2; i >= 0; i--) begin
      @(posedge ref_clk);
      serial_data <= v[i];
      pci_halt_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      pci_halt_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    // released data line shows the inverse, never a stale copy
    serial_data <= ~v[0];
  endtask
endmodule
`default_nettype wire

// file: testbench/crspc_top_tb.sv
// self-checking bench for the request / halt pin control block
// assumes crspc_pkg, crspc_top and crspc_host_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module crspc_top_tb;
  logic ref_clk, reset, strap, mgmt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] ph;
  logic [10:0] gated;
  logic fs_c, fs_b, fs_a;
  logic g_out, g_oe_n, h_out, h_oe_n, c_out, c_oe_n, p_out, p_oe_n;
  logic m_cpu, m_pci, m_g, m_h, m_sd;
  wire logic g_pin, h_pin, c_pin, p_pin;
  int n_fail, checks, cyc;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [2:0] fsv;
  logic [8:0] fr;

  // each shared pin: device wins while its enable is low, else the host
  assign g_pin = g_oe_n ? m_g : g_out;
  assign h_pin = h_oe_n ? m_h : h_out;
  assign c_pin = c_oe_n ? m_cpu : c_out;
  assign p_pin = p_oe_n ? m_pci : p_out;

  crspc_top dut (
    .ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pair5_function_strap(strap), .management_mode(mgmt), .mgmt_serial_data(m_sd),
    .src_clk({11{ph[1]}}), .periph_pair_11_src(ph[0]), .periph_pair_5_src(ph[1]),
    .request_in_g_n_in(g_pin), .request_in_g_n_out(g_out), .request_in_g_n_oe_n(g_oe_n),
    .request_in_h_n_in(h_pin), .request_in_h_n_out(h_out), .request_in_h_n_oe_n(h_oe_n),
    .cpu_halt_n_in(c_pin), .cpu_halt_n_out(c_out), .cpu_halt_n_oe_n(c_oe_n),
    .pci_halt_n_in(p_pin), .pci_halt_n_out(p_out), .pci_halt_n_oe_n(p_oe_n),
    .gated_clk(gated), .freq_sel_c(fs_c), .freq_sel_b(fs_b), .freq_sel_a(fs_a)
  );

  crspc_host_model u_host (
    .ref_clk(ref_clk), .cpu_halt_n(m_cpu), .pci_halt_n(m_pci),
    .req_g_n(m_g), .req_h_n(m_h), .serial_data(m_sd)
  );

  // ------------------------------------------------
  // clock, source phases, monitor
  // ------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    ph <= ph + 4'h1;
  end

  // bus answers are matched against the oldest note; hang guard too
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      report_and_stop();
    end else begin
      if (bvalid === 1'b1 && bready === 1'b1) cmp_bus({32'h0, bresp}, {32'h0, exp_b.pop_front()});
      if (rvalid === 1'b1 && rready === 1'b1) cmp_bus({rresp, rdata}, exp_r.pop_front());
    end
  end

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    @(posedge ref_clk);
    exp_b.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    exp_r.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // settle past sync and low-phase gating, then see which outputs toggle
  task automatic check_run(input logic [10:0] e);
    logic [10:0] seen;
    seen = 11'h000;
    repeat (8) @(posedge ref_clk);
    repeat (16) begin
      @(posedge ref_clk);
      seen = seen | gated;
    end
    cmp_pin(seen, e);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    {reset, strap, mgmt, ph} = {1'b1, 1'b0, 1'b0, 4'h0};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {n_fail, checks, cyc} = {32'h0, 32'h0, 32'h0};
    void'($urandom(15121));
    do_reset();
    axi_read(crspc_pkg::ADDR_OUT_EN, 32'h0c0, crspc_pkg::RESP_OKAY);
    axi_read(crspc_pkg::ADDR_REQ_CFG, 32'h0, crspc_pkg::RESP_OKAY);
    axi_read(crspc_pkg::ADDR_FREE, 32'h0, crspc_pkg::RESP_OKAY);
    axi_read(8'h04, 32'h0, crspc_pkg::RESP_SLVERR);
    axi_write(8'h04, 32'hff, crspc_pkg::RESP_SLVERR);
    axi_write(crspc_pkg::ADDR_STATUS, 32'hff, crspc_pkg::RESP_OKAY);
    cmp_pin({9'h0, g_oe_n, h_oe_n}, 11'h000);
    cmp_pin({9'h0, c_oe_n, p_oe_n}, 11'h003);
    cmp_pin({10'h0, g_out ^ h_out}, 11'h001);
    check_run(11'h7ff);
    $display("test power-up done");
    // either enable bit cleared alone must float both pins
    for (int i = 0; i < 2; i++) begin
      axi_write(crspc_pkg::ADDR_OUT_EN, {24'h0, 8'h40 << i}, crspc_pkg::RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      cmp_pin({9'h0, g_oe_n, h_oe_n}, 11'h003);
    end
    axi_write(crspc_pkg::ADDR_OUT_EN, 32'h0, crspc_pkg::RESP_OKAY);
    axi_write(crspc_pkg::ADDR_REQ_CFG, 32'h30, crspc_pkg::RESP_OKAY);
    axi_read(crspc_pkg::ADDR_REQ_CFG, 32'h30, crspc_pkg::RESP_OKAY);
    axi_write(crspc_pkg::ADDR_OUT_EN, 32'hc0, crspc_pkg::RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    cmp_pin({9'h0, g_oe_n, h_oe_n}, 11'h003);
    u_host.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
    check_run(11'h5ff);
    u_host.set_pins(1'b1, 1'b1, 1'b0, 1'b1);
    check_run(11'h3ff);
    axi_write(crspc_pkg::ADDR_REQ_CFG, 32'h0, crspc_pkg::RESP_OKAY);
    u_host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
    check_run(11'h7ff);
    $display("test request pins done");
    fr = 9'($urandom) & 9'h1f6; // cpu 0 and pci 0 stay stoppable
    axi_write(crspc_pkg::ADDR_FREE, {23'h0, fr}, crspc_pkg::RESP_OKAY);
    axi_read(crspc_pkg::ADDR_FREE, {23'h0, fr}, crspc_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      u_host.set_pins(i[0], i[1], 1'b1, 1'b1);
      check_run({2'h3, i[1] ? 6'h3f : fr[8:3], i[0] ? 3'h7 : fr[2:0]});
    end
    $display("test halt done");
    // release pair 11 so the status sync bits read the host's idle highs
    axi_write(crspc_pkg::ADDR_OUT_EN, 32'h0, crspc_pkg::RESP_OKAY);
    @(posedge ref_clk);
    mgmt <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 2; k++) begin
      fsv = 3'($urandom);
      u_host.shift_sel(fsv);
      repeat (8) @(posedge ref_clk);
      cmp_pin({8'h0, fs_c, fs_b, fs_a}, {8'h0, fsv});
      axi_read(crspc_pkg::ADDR_STATUS, {24'h0, fsv, 5'h0f}, crspc_pkg::RESP_OKAY);
    end
    @(posedge ref_clk);
    mgmt <= 1'b0;
    $display("test serial select done");
    strap <= 1'b1;
    do_reset();
    u_host.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (2) @(posedge ref_clk);
    cmp_pin({9'h0, c_oe_n, p_oe_n}, 11'h000);
    cmp_pin({10'h0, c_pin ^ p_pin}, 11'h001);
    check_run(11'h7ff);
    $display("test strap done");
    report_and_stop();
  end
endmodule
`default_nettype wire
